// *** hdl/rs_decoder_end.sv ***
`default_nettype none
module rs_decoder_end (
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  // link to stream logic
  rs_stream_if.dec            lnk,
  // status
  output logic                busy,
  output logic                recovered
);
  import rs_pkg::*;
  // ***********************************************
  // state
  // ***********************************************
  typedef enum logic [1:0] {ST_CTRL, ST_RUN, ST_STAT} state_e;
  state_e                state_reg, state_next;
  logic [N_W-1:0]        n_reg, n_next, r_reg, r_next, pos_reg, pos_next;
  logic [PSEL_W-1:0]     psel_reg, psel_next;
  logic [CH_W-1:0]       ch_reg, ch_next;
  sym_t                  syn_reg [NUM_CH][R_MAX];
  sym_t                  syn_next [NUM_CH][R_MAX];
  logic [CNT_W-1:0]      z2o_reg, z2o_next, o2z_reg, o2z_next;
  logic                  ctrl_rdy_reg, ctrl_rdy_next, in_rdy_reg, in_rdy_next;
  logic                  stat_vld_reg, stat_vld_next;
  logic [STAT_W-1:0]     stat_dat_reg, stat_dat_next;
  logic                  busy_reg, busy_next, recov_reg, recov_next;
  logic                  out_vld_reg, out_vld_next;
  logic [FIFO_W-1:0]     out_word_reg, out_word_next;
  // fifo side
  logic                  ff_in_vld, ff_in_rdy, ff_out_vld, ff_out_rdy;
  logic [FIFO_W-1:0]     ff_in_dat, ff_out_dat;
  logic [LVL_W-1:0]      ff_lvl;
  // working values
  logic                  cur_punc, fire, info;
  sym_t                  sym_in, sym_cor;
  logic [MARK_W-1:0]     mark_in;
  logic [NUM_CH-1:0]     fail;
  function automatic logic is_punct(input logic [N_W-1:0] p, input logic [N_W-1:0] n,
                                    input logic [N_W-1:0] r, input logic [PSEL_W-1:0] s);
    logic [N_W-1:0] back;
    back     = N_W'(n - p - N_W'(1));
    is_punct = (NUM_PUNC != 0) && !ERASE_EN && (back < r) && PUNC_TAB[s][back[RI_W-1:0]];
  endfunction
  function automatic logic [CNT_W-1:0] popcnt(input sym_t v);
    popcnt = '0;
    for (int b = 0; b < SYM_W; b++) popcnt = popcnt + CNT_W'(v[b]);
  endfunction
  // ***********************************************
  // output buffer
  // ***********************************************
  rs_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (ff_in_vld),
    .in_ready  (ff_in_rdy),
    .in_data   (ff_in_dat),
    .out_valid (ff_out_vld),
    .out_ready (ff_out_rdy),
    .out_data  (ff_out_dat),
    .level     (ff_lvl)
  );
  // ***********************************************
  // controller
  // ***********************************************
  always_comb begin
    state_next    = state_reg;
    n_next        = n_reg;
    r_next        = r_reg;
    psel_next     = psel_reg;
    pos_next      = pos_reg;
    ch_next       = ch_reg;
    syn_next      = syn_reg;
    z2o_next      = z2o_reg;
    o2z_next      = o2z_reg;
    stat_vld_next = stat_vld_reg;
    stat_dat_next = stat_dat_reg;
    recov_next    = recov_reg;
    fail          = '0;
    cur_punc      = is_punct(pos_reg, n_reg, r_reg, psel_reg);
    // punctured slots are filled with zero and consume no input
    sym_in        = cur_punc ? '0 : lnk.in_tdata;
    mark_in       = cur_punc ? '0 : lnk.in_tuser;
    // no correction stage: detection only, corrected equals received
    sym_cor       = sym_in;
    info          = (pos_reg < N_W'(n_reg - r_reg));
    fire          = 1'b0;
    case (state_reg)
      ST_CTRL: begin
        if (lnk.ctrl_tvalid && ctrl_rdy_reg) begin
          n_next     = VAR_N_EN ? lnk.ctrl_tdata[CTRL_N_LSB +: N_W] : N_W'(N_MAX);
          r_next     = VAR_R_EN ? lnk.ctrl_tdata[CTRL_R_LSB +: N_W] : N_W'(R_MAX);
          if (r_next > N_W'(R_MAX)) r_next = N_W'(R_MAX);
          psel_next  = lnk.ctrl_tdata[CTRL_P_LSB +: PSEL_W];
          pos_next   = '0;
          ch_next    = '0;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        fire = cur_punc ? ff_in_rdy : (in_rdy_reg && lnk.in_tvalid);
        if (fire) begin
          for (int c = 0; c < NUM_CH; c++) begin
            for (int i = 0; i < R_MAX; i++) begin
              if ((CH_W'(c) == ch_reg) && (N_W'(i) < r_reg)) begin
                syn_next[c][i] = gf_mul(syn_reg[c][i], ROOT_TAB[i]) ^ sym_in;
              end
            end
          end
          if (STATS_EN) begin
            z2o_next = z2o_reg + popcnt(~sym_in & sym_cor);
            o2z_next = o2z_reg + popcnt(sym_in & ~sym_cor);
          end
          if (ch_reg == CH_W'(NUM_CH - 1)) begin
            ch_next = '0;
            if (pos_reg == N_W'(n_reg - N_W'(1))) begin
              for (int c = 0; c < NUM_CH; c++) begin
                for (int i = 0; i < R_MAX; i++) fail[c] = fail[c] | (syn_next[c][i] != '0);
              end
              stat_dat_next = '0;
              stat_dat_next[STAT_FAIL_LSB +: NUM_CH] = fail;
              stat_dat_next[STAT_Z2O_LSB +: CNT_W]   = z2o_next;
              stat_dat_next[STAT_O2Z_LSB +: CNT_W]   = o2z_next;
              stat_vld_next = 1'b1;
              state_next    = ST_STAT;
            end else begin
              pos_next = N_W'(pos_reg + N_W'(1));
            end
          end else begin
            ch_next = CH_W'(ch_reg + CH_W'(1));
          end
        end
      end
      ST_STAT: begin
        if (lnk.stat_tready && stat_vld_reg) begin
          stat_vld_next = 1'b0;
          z2o_next      = '0;
          o2z_next      = '0;
          for (int c = 0; c < NUM_CH; c++) begin
            for (int i = 0; i < R_MAX; i++) syn_next[c][i] = '0;
          end
          state_next = ST_CTRL;
        end
      end
      default: begin
        // unreachable code: return state, counters and syndromes to reset values; recovered is set to SELF_REC
        state_next    = ST_CTRL;
        n_next        = '0;
        r_next        = '0;
        psel_next     = '0;
        pos_next      = '0;
        ch_next       = '0;
        z2o_next      = '0;
        o2z_next      = '0;
        stat_vld_next = 1'b0;
        stat_dat_next = '0;
        for (int c = 0; c < NUM_CH; c++) begin
          for (int i = 0; i < R_MAX; i++) syn_next[c][i] = '0;
        end
        recov_next = SELF_REC;
      end
    endcase
    // fifo keeps two slots spare so a registered ready never overruns it
    ctrl_rdy_next = (state_next == ST_CTRL);
    in_rdy_next   = (state_next == ST_RUN) && !is_punct(pos_next, n_next, r_next, psel_next) &&
                    (ff_lvl <= LVL_W'(FIFO_DEPTH - FIFO_ROOM));
    busy_next     = (state_next != ST_CTRL);
    ff_in_vld     = fire && (OUT_CHK_EN || info);
    ff_in_dat     = '0;
    ff_in_dat[OUT_SYM_LSB +: SYM_W] = sym_cor;
    ff_in_dat[OUT_INFO]             = INFO_EN && OUT_CHK_EN && info;
    if (DEL_EN) ff_in_dat[OUT_DEL_LSB +: SYM_W] = sym_in;
    ff_in_dat[OUT_W +: MARK_W]      = mark_in;
  end
  // ***********************************************
  // output register stage
  // ***********************************************
  always_comb begin
    ff_out_rdy    = !out_vld_reg || lnk.out_tready;
    out_vld_next  = out_vld_reg;
    out_word_next = out_word_reg;
    if (ff_out_rdy) begin
      out_vld_next = ff_out_vld;
      if (ff_out_vld) out_word_next = ff_out_dat;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_CTRL;
      n_reg        <= '0;
      r_reg        <= '0;
      psel_reg     <= '0;
      pos_reg      <= '0;
      ch_reg       <= '0;
      z2o_reg      <= '0;
      o2z_reg      <= '0;
      ctrl_rdy_reg <= 1'b0;
      in_rdy_reg   <= 1'b0;
      stat_vld_reg <= 1'b0;
      stat_dat_reg <= '0;
      busy_reg     <= 1'b0;
      recov_reg    <= 1'b0;
      out_vld_reg  <= 1'b0;
      out_word_reg <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        for (int i = 0; i < R_MAX; i++) syn_reg[c][i] <= '0;
      end
    end else begin
      state_reg    <= state_next;
      n_reg        <= n_next;
      r_reg        <= r_next;
      psel_reg     <= psel_next;
      pos_reg      <= pos_next;
      ch_reg       <= ch_next;
      z2o_reg      <= z2o_next;
      o2z_reg      <= o2z_next;
      ctrl_rdy_reg <= ctrl_rdy_next;
      in_rdy_reg   <= in_rdy_next;
      stat_vld_reg <= stat_vld_next;
      stat_dat_reg <= stat_dat_next;
      busy_reg     <= busy_next;
      recov_reg    <= recov_next;
      out_vld_reg  <= out_vld_next;
      out_word_reg <= out_word_next;
      syn_reg      <= syn_next;
    end
  end
  // clock enable and synchronous reset pins are not configured
  assign lnk.ctrl_tready = ctrl_rdy_reg;
  assign lnk.in_tready   = in_rdy_reg;
  assign lnk.out_tvalid  = out_vld_reg;
  assign lnk.out_tdata   = out_word_reg[OUT_W-1:0];
  assign lnk.out_tuser   = out_word_reg[OUT_W +: MARK_W];
  assign lnk.stat_tvalid = stat_vld_reg;
  assign lnk.stat_tdata  = stat_dat_reg;
  assign busy            = busy_reg;
  assign recovered       = recov_reg;
endmodule
`default_nettype wire

// *** hdl/rs_fifo.sv ***
`default_nettype none
module rs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  // fill side
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [WIDTH-1:0]             in_data,
  // drain side
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [WIDTH-1:0]                  out_data,
  // fill level
  output logic [$clog2(DEPTH):0]            level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign level     = cnt_reg;
  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  // storage carries no reset; only written slots are ever read
  always_ff @(posedge clk_sys) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end
endmodule
`default_nettype wire

// *** hdl/rs_pkg.sv ***
`default_nettype none
package rs_pkg;
  // ***********************************************
  // code configuration
  // ***********************************************
  localparam int SYM_W      = 8;
  localparam int FIELD_POLY = 0;   // decimal form, bit i = coefficient of x^i; 0 selects default
  localparam int SCALE_H    = 1;   // must be coprime with 2^SYM_W-1
  localparam int GEN_START  = 0;
  localparam int N_MAX      = 255;
  localparam int K_MIN      = 239;
  localparam int R_MAX      = N_MAX - K_MIN;
  localparam int RI_W       = $clog2(R_MAX);
  localparam int NUM_CH     = 2;
  localparam int CH_W       = 1;
  localparam int MARK_W     = 4;
  localparam int NUM_PUNC   = 2;
  localparam int PSEL_W     = 1;
  localparam bit VAR_N_EN   = 1'b1;
  localparam bit VAR_R_EN   = 1'b1;
  localparam bit OUT_CHK_EN = 1'b1;
  localparam bit INFO_EN    = OUT_CHK_EN;
  localparam bit DEL_EN     = 1'b1;
  localparam bit STATS_EN   = 1'b1;
  localparam bit ERASE_EN   = 1'b0;
  localparam bit SELF_REC   = 1'b1;
  localparam int N_MIN      = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_ROOM  = 2;
  localparam int LVL_W      = $clog2(FIFO_DEPTH) + 1;
  // ***********************************************
  // word layouts
  // ***********************************************
  localparam int N_W        = 8;
  localparam int CTRL_N_LSB = 0;
  localparam int CTRL_R_LSB = 8;
  localparam int CTRL_P_LSB = 16;
  localparam int CTRL_W     = 24;
  localparam int OUT_SYM_LSB = 0;
  localparam int OUT_INFO    = 8;
  localparam int OUT_DEL_LSB = 9;
  localparam int OUT_W       = 17;
  localparam int CNT_W       = 8;
  localparam int STAT_FAIL_LSB = 0;
  localparam int STAT_Z2O_LSB  = 8;
  localparam int STAT_O2Z_LSB  = 16;
  localparam int STAT_W        = 24;
  localparam int FIFO_W        = OUT_W + MARK_W;
  typedef logic [SYM_W-1:0] sym_t;
  typedef logic [R_MAX-1:0] punc_mask_t;
  typedef sym_t root_tab_t [R_MAX];
  // bit 0 = last symbol of the block
  localparam punc_mask_t PUNC_TAB [NUM_PUNC] = '{16'h0000, 16'h0003};
  localparam int NUM_LEGAL_R = 4;
  localparam logic [N_W-1:0] LEGAL_R [NUM_LEGAL_R] = '{8'h08, 8'h0C, 8'h0E, 8'h10};
  // ***********************************************
  // galois field
  // ***********************************************
  function automatic int default_poly(input int w);
    case (w)
      3:       default_poly = 32'h0000000B;
      4:       default_poly = 32'h00000013;
      5:       default_poly = 32'h00000025;
      6:       default_poly = 32'h00000043;
      7:       default_poly = 32'h00000089;
      8:       default_poly = 32'h0000011D;
      9:       default_poly = 32'h00000211;
      10:      default_poly = 32'h00000409;
      11:      default_poly = 32'h00000805;
      12:      default_poly = 32'h00001053;
      default: default_poly = 32'h00000000;
    endcase
  endfunction
  localparam int   POLY      = (FIELD_POLY == 0) ? default_poly(SYM_W) : FIELD_POLY;
  localparam sym_t POLY_LOW  = POLY[SYM_W-1:0];
  localparam int   FIELD_ORD = (1 << SYM_W) - 1;
  function automatic sym_t gf_mul(input sym_t a, input sym_t b);
    sym_t p;
    sym_t aa;
    p  = '0;
    aa = a;
    for (int i = 0; i < SYM_W; i++) begin
      if (b[i]) p = p ^ aa;
      aa = aa[SYM_W-1] ? ({aa[SYM_W-2:0], 1'b0} ^ POLY_LOW) : {aa[SYM_W-2:0], 1'b0};
    end
    return p;
  endfunction
  function automatic root_tab_t make_roots();
    root_tab_t t;
    sym_t      v;
    for (int i = 0; i < R_MAX; i++) begin
      v = SYM_W'(1);
      for (int e = 0; e < (SCALE_H * (GEN_START + i)) % FIELD_ORD; e++) v = gf_mul(v, SYM_W'(2));
      t[i] = v;
    end
    return t;
  endfunction
  localparam root_tab_t ROOT_TAB = make_roots();
endpackage
`default_nettype wire

// *** hdl/rs_stream_end.sv ***
`default_nettype none
module rs_hold_stage #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         up_valid,
  output logic              up_ready,
  input  wire logic [W-1:0] up_data,
  output logic              dn_valid,
  input  wire logic         dn_ready,
  output logic [W-1:0]      dn_data
);
  // half-rate holding slot: every output is a flip-flop
  logic         vld_reg, vld_next, rdy_reg, rdy_next;
  logic [W-1:0] dat_reg, dat_next;
  always_comb begin
    vld_next = vld_reg && !dn_ready;
    dat_next = dat_reg;
    if (up_valid && rdy_reg) begin
      vld_next = 1'b1;
      dat_next = up_data;
    end
    rdy_next = !vld_next;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vld_reg <= 1'b0;
      rdy_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      vld_reg <= vld_next;
      rdy_reg <= rdy_next;
      dat_reg <= dat_next;
    end
  end
  assign up_ready = rdy_reg;
  assign dn_valid = vld_reg;
  assign dn_data  = dat_reg;
endmodule

module rs_stream_end (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  // link to decoder
  rs_stream_if.usr                          lnk,
  // block settings from user
  input  wire logic                         blk_valid,
  output logic                              blk_ready,
  input  wire logic [rs_pkg::N_W-1:0]       blk_n,
  input  wire logic [rs_pkg::N_W-1:0]       blk_r,
  input  wire logic [rs_pkg::PSEL_W-1:0]    blk_psel,
  output logic                              blk_rejected,
  // symbols from user
  input  wire logic                         sym_valid,
  output logic                              sym_ready,
  input  wire logic [rs_pkg::SYM_W-1:0]     sym_data,
  input  wire logic [rs_pkg::MARK_W-1:0]    sym_mark,
  // decoded symbols to user
  output logic                              dat_valid,
  input  wire logic                         dat_ready,
  output logic [rs_pkg::OUT_W-1:0]          dat_word,
  output logic [rs_pkg::MARK_W-1:0]         dat_mark,
  // block status to user
  output logic                              st_valid,
  input  wire logic                         st_ready,
  output logic [rs_pkg::STAT_W-1:0]         st_word
);
  import rs_pkg::*;
  logic              legal, blk_take, rej_reg, rej_next;
  logic [CTRL_W-1:0] ctrl_word;
  function automatic logic r_is_legal(input logic [N_W-1:0] r);
    r_is_legal = 1'b0;
    for (int i = 0; i < NUM_LEGAL_R; i++) r_is_legal = r_is_legal | (LEGAL_R[i] == r);
  endfunction
  always_comb begin
    legal = (!VAR_R_EN || r_is_legal(blk_r)) &&
            (!VAR_N_EN || ((blk_n > blk_r) && (blk_n >= N_W'(N_MIN))));
    ctrl_word = '0;
    if (VAR_N_EN) ctrl_word[CTRL_N_LSB +: N_W] = blk_n;
    if (VAR_R_EN) ctrl_word[CTRL_R_LSB +: N_W] = blk_r;
    ctrl_word[CTRL_P_LSB +: PSEL_W] = blk_psel;
    blk_take = blk_valid && blk_ready;
    // illegal settings are consumed and dropped, never forwarded
    rej_next = blk_take && !legal;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rej_reg <= 1'b0;
    else       rej_reg <= rej_next;
  end
  assign blk_rejected = rej_reg;
  rs_hold_stage #(.W(CTRL_W)) u_ctrl (
    .clk_sys (clk_sys), .nrst (nrst),
    .up_valid (blk_valid && legal), .up_ready (blk_ready), .up_data (ctrl_word),
    .dn_valid (lnk.ctrl_tvalid), .dn_ready (lnk.ctrl_tready), .dn_data (lnk.ctrl_tdata)
  );
  rs_hold_stage #(.W(SYM_W + MARK_W)) u_sym (
    .clk_sys (clk_sys), .nrst (nrst),
    .up_valid (sym_valid), .up_ready (sym_ready), .up_data ({sym_mark, sym_data}),
    .dn_valid (lnk.in_tvalid), .dn_ready (lnk.in_tready), .dn_data ({lnk.in_tuser, lnk.in_tdata})
  );
  rs_hold_stage #(.W(OUT_W + MARK_W)) u_dat (
    .clk_sys (clk_sys), .nrst (nrst),
    .up_valid (lnk.out_tvalid), .up_ready (lnk.out_tready), .up_data ({lnk.out_tuser, lnk.out_tdata}),
    .dn_valid (dat_valid), .dn_ready (dat_ready), .dn_data ({dat_mark, dat_word})
  );
  rs_hold_stage #(.W(STAT_W)) u_st (
    .clk_sys (clk_sys), .nrst (nrst),
    .up_valid (lnk.stat_tvalid), .up_ready (lnk.stat_tready), .up_data (lnk.stat_tdata),
    .dn_valid (st_valid), .dn_ready (st_ready), .dn_data (st_word)
  );
endmodule
`default_nettype wire

// *** hdl/rs_stream_if.sv ***
`default_nettype none
interface rs_stream_if;
  // control stream
  logic                              ctrl_tvalid;
  logic                              ctrl_tready;
  logic [rs_pkg::CTRL_W-1:0]         ctrl_tdata;
  // input symbol stream
  logic                              in_tvalid;
  logic                              in_tready;
  logic [rs_pkg::SYM_W-1:0]          in_tdata;
  logic [rs_pkg::MARK_W-1:0]         in_tuser;
  // output symbol stream
  logic                              out_tvalid;
  logic                              out_tready;
  logic [rs_pkg::OUT_W-1:0]          out_tdata;
  logic [rs_pkg::MARK_W-1:0]         out_tuser;
  // status stream
  logic                              stat_tvalid;
  logic                              stat_tready;
  logic [rs_pkg::STAT_W-1:0]         stat_tdata;
  modport dec (
    input  ctrl_tvalid, ctrl_tdata, in_tvalid, in_tdata, in_tuser, out_tready, stat_tready,
    output ctrl_tready, in_tready, out_tvalid, out_tdata, out_tuser, stat_tvalid, stat_tdata
  );
  modport usr (
    output ctrl_tvalid, ctrl_tdata, in_tvalid, in_tdata, in_tuser, out_tready, stat_tready,
    input  ctrl_tready, in_tready, out_tvalid, out_tdata, out_tuser, stat_tvalid, stat_tdata
  );
endinterface
`default_nettype wire

// *** sim/rs_link_props.sv ***
`default_nettype none
module rs_link_props (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       nrst,
  // link signals
  input wire logic                       ctrl_tvalid,
  input wire logic                       ctrl_tready,
  input wire logic [rs_pkg::CTRL_W-1:0]  ctrl_tdata,
  input wire logic                       in_tvalid,
  input wire logic                       in_tready,
  input wire logic                       out_tvalid,
  input wire logic                       out_tready,
  input wire logic [rs_pkg::OUT_W-1:0]   out_tdata,
  input wire logic [rs_pkg::MARK_W-1:0]  out_tuser,
  input wire logic                       stat_tvalid,
  input wire logic                       stat_tready,
  input wire logic [rs_pkg::STAT_W-1:0]  stat_tdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import rs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence ctrl_take; ctrl_tvalid && ctrl_tready; endsequence
  sequence in_take; in_tvalid && in_tready; endsequence
  sequence stat_take; stat_tvalid && stat_tready; endsequence
  ctrl_once_a: assert property (ctrl_take |=> !ctrl_tready)
    else $error("control taken twice");
  run_start_a: assert property (ctrl_take |=> in_tready)
    else $error("no symbol slot after control");
  legal_r_a: assert property (ctrl_take |-> ctrl_tdata[15:8] inside {8'h08, 8'h0C, 8'h0E, 8'h10}
    && ctrl_tdata[7:0] > ctrl_tdata[15:8] && ctrl_tdata[7:0] >= 8'h05) else $error("illegal block settings");
  ctrl_hold_a: assert property (ctrl_tvalid && !ctrl_tready |=> ctrl_tvalid && $stable(ctrl_tdata))
    else $error("control word dropped");
  out_hold_a: assert property (out_tvalid && !out_tready |=> out_tvalid && $stable(out_tdata)
    && $stable(out_tuser)) else $error("output word dropped");
  delayed_eq_a: assert property (out_tvalid |-> out_tdata[16:9] == out_tdata[7:0])
    else $error("delayed symbol differs");
  stat_zero_a: assert property (stat_tvalid |-> stat_tdata[23:8] == 16'h0000)
    else $error("correction counts nonzero");
  stat_idle_a: assert property (stat_take |-> ##[1:2] ctrl_tready)
    else $error("no idle after status");
  in_stops_a: assert property (stat_tvalid |-> !in_tready)
    else $error("input open during status");
  out_after_a: assert property (in_take |-> ##[2:100] out_tvalid)
    else $error("symbol never delivered");
endmodule
`default_nettype wire

// *** sim/tb_rs_decoder_end.sv ***
`default_nettype none
module tb_rs_decoder_end;
  timeunit 1ns;
  timeprecision 1ps;
  import rs_pkg::*;
  logic clk_sys, nrst, blk_valid, blk_ready, blk_rejected, sym_valid, sym_ready;
  logic dat_valid, dat_ready, st_valid, st_ready, busy, recovered;
  logic [N_W-1:0] blk_n, blk_r;
  logic [PSEL_W-1:0] blk_psel;
  logic [SYM_W-1:0] sym_data;
  logic [MARK_W-1:0] sym_mark, dat_mark;
  logic [OUT_W-1:0] dat_word;
  logic [STAT_W-1:0] st_word;
  logic [FIFO_W-1:0] dq[$];
  logic [STAT_W-1:0] sq[$];
  int mismatches, n_compared;
  rs_stream_if lnk();
  rs_decoder_end u_rs_decoder_end (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk), .busy(busy), .recovered(recovered));
  rs_stream_end u_rs_stream_end (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk), .blk_valid(blk_valid),
    .blk_ready(blk_ready), .blk_n(blk_n), .blk_r(blk_r), .blk_psel(blk_psel), .blk_rejected(blk_rejected),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .sym_data(sym_data), .sym_mark(sym_mark),
    .dat_valid(dat_valid), .dat_ready(dat_ready), .dat_word(dat_word), .dat_mark(dat_mark),
    .st_valid(st_valid), .st_ready(st_ready), .st_word(st_word));
  rs_link_props u_rs_link_props (.clk_sys(clk_sys), .nrst(nrst), .ctrl_tvalid(lnk.ctrl_tvalid),
    .ctrl_tready(lnk.ctrl_tready), .ctrl_tdata(lnk.ctrl_tdata), .in_tvalid(lnk.in_tvalid),
    .in_tready(lnk.in_tready), .out_tvalid(lnk.out_tvalid), .out_tready(lnk.out_tready),
    .out_tdata(lnk.out_tdata), .out_tuser(lnk.out_tuser), .stat_tvalid(lnk.stat_tvalid),
    .stat_tready(lnk.stat_tready), .stat_tdata(lnk.stat_tdata));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (dat_valid && dat_ready) dq.push_back({dat_mark, dat_word});
    if (st_valid && st_ready) sq.push_back(st_word);
  end
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  function automatic bit coprime(input int a, input int b);
    while (b != 0) {a, b} = {b, a % b};
    return a == 1;
  endfunction
  task test_done;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task send_blk(input logic [7:0] n, input logic [7:0] r, input logic p);
    @(posedge clk_sys);
    {blk_valid, blk_n, blk_r, blk_psel} <= {1'b1, n, r, p};
    @(posedge clk_sys);
    while (blk_ready !== 1'b1) @(posedge clk_sys);
    blk_valid <= 1'b0;
  endtask
  task send_sym(input logic [7:0] d, input logic [3:0] m);
    @(posedge clk_sys);
    {sym_valid, sym_data, sym_mark} <= {1'b1, d, m};
    @(posedge clk_sys);
    while (sym_ready !== 1'b1) @(posedge clk_sys);
    sym_valid <= 1'b0;
  endtask
  // one block on both channels; a 01 symbol at position 0 of each channel set in bad
  task run_blk(input int n, input int r, input logic p, input logic [1:0] bad);
    int np;
    logic [7:0] e;
    np = p ? n - 2 : n;
    dq.delete();
    sq.delete();
    send_blk(8'(n), 8'(r), p);
    repeat (2) @(posedge clk_sys);
    chk(busy === 1'b1, "idle during block");
    for (int i = 0; i < np * 2; i++) send_sym((bad[i%2] && i < 2) ? 8'h01 : 8'h00, 4'(i));
    for (int t = 0; t < 64 && sq.size() == 0; t++) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
    chk(busy === 1'b0 && recovered === 1'b0, "busy after block");
    chk(sq.size() == 1 && sq[0][1:0] === bad && sq[0][23:8] === 16'h0000, "status word");
    chk(dq.size() == 2 * n, "word count");
    foreach (dq[i]) begin
      e = (bad[i%2] && i < 2) ? 8'h01 : 8'h00;
      chk(dq[i][7:0] === e && dq[i][16:9] === e && dq[i][8] === (i / 2 < n - r), "output word");
      if (i < np * 2) chk(dq[i][20:17] === 4'(i), "marker");
    end
  endtask
  task test_clean; run_blk(10, 8, 1'b0, 2'b00); endtask
  task test_err; run_blk(13, 12, 1'b0, 2'b10); endtask
  task test_punc; run_blk(255, 16, 1'b1, 2'b01); endtask
  task test_reject;
    logic seen;
    for (int k = 0; k < 2; k++) begin
      seen = 1'b0;
      send_blk(k ? 8'h08 : 8'h14, k ? 8'h08 : 8'h0A, 1'b0);
      repeat (4) @(posedge clk_sys) seen |= blk_rejected;
      chk(seen, "bad block accepted");
    end
    chk(recovered === 1'b0, "spurious recovery");
  endtask
  initial begin
    {nrst, blk_valid, sym_valid, blk_n, blk_r, blk_psel, sym_data, sym_mark} = '0;
    {dat_ready, st_ready} = 2'b11;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    chk(coprime(SCALE_H, FIELD_ORD), "scale not coprime");
    chk(FIELD_POLY != 0 || POLY == 285, "default field polynomial");
    chk(ROOT_TAB[8] === 8'h1D, "field reduction");
    test_clean();
    test_err();
    test_punc();
    test_reject();
    test_done();
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
